/* File: bench/eight_bit_compare_timer_tb.sv */
// Self-checking testbench of the 8-bit compare timer
`timescale 1ns/1ps
module eight_bit_compare_timer_tb import timer_pkg::*;;
  logic clk = 1'b0; // 20 MHz system clock
  logic rst_n = 1'b0; // Chip reset, active low
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf; // Lane enables driven with each request
  logic [3:0] lane_mask = 4'hf; // Lanes the next access will enable
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_clk, ext_rst, timer_out_ch0, match_irq_a, match_irq_b, wrap_irq;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0; // Free cycle count for period checks

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  eight_bit_compare_timer dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_count_clock_in(ext_clk), .ext_count_reset_in(ext_rst), .timer_out_ch0(timer_out_ch0),
    .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .wrap_irq(wrap_irq));
  ext_pin_source ext_u (.clk(clk), .ext_clk(ext_clk), .ext_rst(ext_rst));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; the request holds until waitrequest is sampled low at a rising edge,
  // read data is taken at that edge, and only then is the request released
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= lane_mask;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk(8'(n), 8'h02); // One wait state, so the answer comes at the second edge
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  // Waits for the timer output to change, bounded, and returns the cycle
  task automatic wait_out(output int t);
    logic v;
    int n;
    v = timer_out_ch0;
    n = 0;
    while (timer_out_ch0 === v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, timer_out_ch0}, {7'h0, ~v});
    t = cyc;
  endtask

  task automatic t_reset;
    chk({7'h0, timer_out_ch0}, 8'h00);
    rd(OFS_COUNT, COUNT_RST);
    rd(OFS_CONST_A, CONST_RST);
    rd(OFS_CONST_B, CONST_RST);
    rd(OFS_CONTROL, CONTROL_RST);
    rd(OFS_STATUS, STATUS_RST);
    rd(5'h14, 8'h00);
    // A write with lane 0 disabled must be ignored
    lane_mask = 4'he;
    wr(OFS_CONST_A, 8'h12);
    lane_mask = 4'hf;
    rd(OFS_CONST_A, CONST_RST);
    wr(OFS_STATUS, 8'hff);
    rd(OFS_STATUS, 8'h1f);
    $display("test reset done");
  endtask

  // Each internal rate with match A clearing the count and toggling the output
  task automatic t_internal;
    int t0, t1;
    logic [7:0] cst[3] = '{8'h03, 8'h01, 8'h00};
    int per[3] = '{32, 128, 1024};
    wr(OFS_STATUS, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONTROL, 8'h40);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CONST_A, cst[i]);
      wr(OFS_CONTROL, 8'h48 | 8'(i + 1));
      wait_out(t0);
      wait_out(t1);
      chk({7'h0, (t1 - t0) == per[i]}, 8'h01);
    end
    chk({7'h0, match_irq_a}, 8'h01);
    wr(OFS_CONTROL, 8'h40);
    rd(OFS_STATUS, 8'h53);
    wr(OFS_STATUS, 8'h03);
    rd(OFS_STATUS, 8'h13);
    chk({7'h0, match_irq_a}, 8'h00);
    $display("test internal done");
  endtask

  // Wrap from FF to 00 on external rising edges
  task automatic t_wrap;
    wr(OFS_CONTROL, 8'h20);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_COUNT, 8'hfe);
    wr(OFS_CONTROL, 8'h25);
    ext_u.clk_pulses(2);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_STATUS, 8'hb0);
    chk({7'h0, wrap_irq}, 8'h01);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h10);
    chk({7'h0, wrap_irq}, 8'h00);
    $display("test wrap done");
  endtask

  // External edge kinds, then the reset pin clears the count
  task automatic t_ext;
    wr(OFS_CONTROL, 8'h1d);
    ext_u.clk_pulses(1);
    rd(OFS_COUNT, 8'h01);
    wr(OFS_CONTROL, 8'h1e);
    ext_u.clk_pulses(1);
    rd(OFS_COUNT, 8'h02);
    wr(OFS_CONTROL, 8'h1f);
    ext_u.clk_pulses(1);
    rd(OFS_COUNT, 8'h04);
    ext_u.rst_pulse;
    rd(OFS_COUNT, 8'h00);
    $display("test ext done");
  endtask

  // Both matches together with conflicting output actions
  task automatic t_prio;
    logic [7:0] os[4] = '{8'h09, 8'h0d, 8'h06, 8'h04};
    logic [7:0] lvl[4] = '{8'h01, 8'h00, 8'h01, 8'h00};
    wr(OFS_CONTROL, 8'h85);
    wr(OFS_CONST_A, 8'h02);
    wr(OFS_CONST_B, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_COUNT, 8'h02);
      wr(OFS_STATUS, os[i]);
      ext_u.clk_pulses(1);
      chk({7'h0, timer_out_ch0}, lvl[i]);
    end
    rd(OFS_STATUS, 8'hd4);
    chk({7'h0, match_irq_b}, 8'h01);
    chk({7'h0, match_irq_a}, 8'h00);
    // Clearing the flags, then writing control with enable B off, leaves request B low
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CONTROL, 8'h15);
    chk({7'h0, match_irq_b}, 8'h00);
    // Match B now clears the count
    wr(OFS_COUNT, 8'h02);
    ext_u.clk_pulses(1);
    rd(OFS_COUNT, 8'h00);
    $display("test prio done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_internal;
    t_wrap;
    t_ext;
    t_prio;
    give_verdict;
  end

  // Whole run needs under 3000 cycles; give it plenty
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule

/* File: bench/ext_pin_source.sv */
// Model of the far-side logic driving the external count clock and counter reset pins
`timescale 1ns/1ps
module ext_pin_source (
  input wire logic clk,
  output logic ext_clk,
  output logic ext_rst
);
  // Both pins rest low between bursts; nothing toggles unless a task is called
  initial begin
    ext_clk = 1'b0;
    ext_rst = 1'b0;
  end

  // Whole pulses of three clk periods per level, wide enough even for both-edge counting
  task automatic clk_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // One counter reset pulse of two clk periods
  task automatic rst_pulse;
    @(posedge clk);
    ext_rst <= 1'b1;
    repeat (2) @(posedge clk);
    ext_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: bench/timer_properties.sv */
// Concurrent checks on the ports of the compare timer
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
#(
  parameter int unsigned PRESCALE_W = PRE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ext_count_clock_in,
  input wire logic ext_count_reset_in,
  input wire logic timer_out_ch0,
  input wire logic match_irq_a,
  input wire logic match_irq_b,
  input wire logic wrap_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic req; // Any bus request pending
  assign req = avs_read | avs_write;

  // Steps of a bus access
  sequence s_req_start;
    req && !$past(req);
  endsequence
  sequence s_rd_done(logic [ADDR_W-1:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  sequence s_wr_done;
    avs_write && !avs_waitrequest;
  endsequence

  property p_wait_once;
    s_req_start |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("wait state not one cycle");
  property p_idle_ready;
    !req |-> !avs_waitrequest;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("waitrequest while idle");
  property p_upper_zero;
    avs_read && !avs_waitrequest |-> avs_readdata[DATA_W-1:8] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read lanes not zero");
  // Reads of holes must come back empty
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address > OFS_STATUS || avs_address[1:0] != 2'h0)
      |-> avs_readdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_fixed_bit;
    s_rd_done(OFS_STATUS) |-> avs_readdata[STS_FIXED];
  endproperty
  a_fixed_bit: assert property (p_fixed_bit) else $error("status bit 4 not one");
  // Read data is captured a cycle early, so compare with the request line of that cycle
  property p_flag_a;
    s_rd_done(OFS_STATUS) |-> !$past(match_irq_a) || avs_readdata[STS_FLAG_A];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("irq a without flag a");
  property p_flag_b;
    s_rd_done(OFS_STATUS) |-> !$past(match_irq_b) || avs_readdata[STS_FLAG_B];
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("irq b without flag b");
  property p_flag_wrap;
    s_rd_done(OFS_STATUS) |-> !$past(wrap_irq) || avs_readdata[STS_WRAP];
  endproperty
  a_flag_wrap: assert property (p_flag_wrap) else $error("wrap irq without flag");
  // Requests drop only after software writes
  property p_clr_a;
    $fell(match_irq_a) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("irq a dropped without write");
  property p_clr_b;
    $fell(match_irq_b) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("irq b dropped without write");
  property p_clr_wrap;
    $fell(wrap_irq) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_clr_wrap: assert property (p_clr_wrap) else $error("wrap irq dropped without write");
  c_wr: cover property (s_wr_done);
endmodule

bind eight_bit_compare_timer timer_checker #(.PRESCALE_W(PRESCALE_W)) chk_u (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ext_count_clock_in(ext_count_clock_in), .ext_count_reset_in(ext_count_reset_in),
  .timer_out_ch0(timer_out_ch0), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
  .wrap_irq(wrap_irq));

/* File: design/eight_bit_compare_timer.sv */
// Eight-bit compare timer channel with an Avalon-MM register slave
`timescale 1ns/1ps
module eight_bit_compare_timer
  import timer_pkg::*;
#(
  parameter int unsigned PRESCALE_W = PRE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_count_clock_in,
  input wire logic ext_count_reset_in,
  output logic timer_out_ch0,
  output logic match_irq_a,
  output logic match_irq_b,
  output logic wrap_irq
);
  // The prescaler taps need at least ten bits
  if (PRESCALE_W < PRE_W) begin : g_bad_prescale
    $error("PRESCALE_W below the width needed for divide-by-1024");
  end

  // All state of the channel outside the prescaler and edge detectors in one packed struct
  typedef struct packed {
    logic [7:0] timer_count;       // Counter value
    logic [7:0] time_constant_a;   // Compare constant A
    logic [7:0] time_constant_b;   // Compare constant B
    logic [7:0] timer_control;     // Enables, clear select, clock select
    logic match_flag_b;            // Sticky compare flag B
    logic match_flag_a;            // Sticky compare flag A
    logic wrap_flag;               // Sticky overflow flag
    logic [3:0] output_action_select; // B in upper pair, A in lower
    logic tout;                    // Timer output level
    logic int_lvl_prev;            // Selected internal source, last cycle
    logic ack;                     // Bus access in its final cycle
    logic [7:0] rdata;             // Read data for the final cycle
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  // Prescaler levels
  logic lvl_div8;
  logic lvl_div64;
  logic lvl_div1024;

  // External pin edges
  logic clk_in_rise;
  logic clk_in_fall;
  logic rst_in_rise;

  // Decoded control fields
  clock_sel_t clock_source_select;
  clear_sel_t clear_sel;
  logic counter_clear_sel_hi;
  logic counter_clear_sel_lo;
  logic match_irq_enable_a;
  logic match_irq_enable_b;
  logic wrap_irq_enable;

  // Bus decode
  logic access;
  logic wr_fire;
  logic wr_count;
  logic wr_const_a;
  logic wr_const_b;
  logic wr_control;
  logic wr_status;
  logic [7:0] wbyte;
  logic [7:0] status_view;

  // Counting and compare
  logic int_lvl;
  logic tick_int;
  logic tick_ext;
  logic tick;
  logic match_a;
  logic match_b;
  logic clear_cnt;
  logic wrap_evt;
  out_act_t act_a;
  out_act_t act_b;
  out_act_t act;

  // Divider for the internal sources
  timer_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .lvl_div8(lvl_div8),
    .lvl_div64(lvl_div64),
    .lvl_div1024(lvl_div1024)
  );

  // Edges of the external count clock
  timer_edge_detect u_clk_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin(ext_count_clock_in),
    .rise(clk_in_rise),
    .fall(clk_in_fall)
  );

  // Edges of the external counter reset
  timer_edge_detect u_rst_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin(ext_count_reset_in),
    .rise(rst_in_rise),
    .fall()
  );

  // Field extraction from timer_control
  assign clock_source_select = clock_sel_t'(s_q.timer_control[CTL_CKS_HI:CTL_CKS_LO]);
  assign counter_clear_sel_hi = s_q.timer_control[CTL_CLR_HI];
  assign counter_clear_sel_lo = s_q.timer_control[CTL_CLR_LO];
  assign clear_sel = clear_sel_t'({counter_clear_sel_hi, counter_clear_sel_lo});
  assign match_irq_enable_b = s_q.timer_control[CTL_IRQ_EN_B];
  assign match_irq_enable_a = s_q.timer_control[CTL_IRQ_EN_A];
  assign wrap_irq_enable = s_q.timer_control[CTL_WRAP_EN];

  // Status as software sees it; the fixed bit always reads one
  assign status_view = {s_q.match_flag_b, s_q.match_flag_a, s_q.wrap_flag, 1'b1,
                        s_q.output_action_select};

  // Bus handshake: one wait cycle, then the final cycle where the
  // write lands and read data stands
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~s_q.ack;
  assign avs_readdata = {24'h000000, s_q.rdata};

  // Writes land only in the final cycle and only with lane 0 enabled;
  // upper lanes hold nothing and are ignored
  assign wr_fire = avs_write & s_q.ack & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Address decode for writes; unmapped offsets are ignored
  always_comb begin
    wr_count = 1'b0;
    wr_const_a = 1'b0;
    wr_const_b = 1'b0;
    wr_control = 1'b0;
    wr_status = 1'b0;
    if (avs_address == OFS_COUNT) begin
      wr_count = wr_fire;
    end else if (avs_address == OFS_CONST_A) begin
      wr_const_a = wr_fire;
    end else if (avs_address == OFS_CONST_B) begin
      wr_const_b = wr_fire;
    end else if (avs_address == OFS_CONTROL) begin
      wr_control = wr_fire;
    end else if (avs_address == OFS_STATUS) begin
      wr_status = wr_fire;
    end
  end

  // Internal source level; stopped codes and external codes count as low,
  // so leaving a high internal source looks like a falling edge
  always_comb begin
    case (clock_source_select)
      CKS_DIV8: int_lvl = lvl_div8;
      CKS_DIV64: int_lvl = lvl_div64;
      CKS_DIV1024: int_lvl = lvl_div1024;
      default: int_lvl = 1'b0;
    endcase
  end

  // Falling edge of the selected level, including one made by a select
  // change from a high source to a low one
  assign tick_int = s_q.int_lvl_prev & ~int_lvl;

  // External source edges; short pulses from outside may be missed
  always_comb begin
    case (clock_source_select)
      CKS_EXT_RISE: tick_ext = clk_in_rise;
      CKS_EXT_FALL: tick_ext = clk_in_fall;
      CKS_EXT_BOTH: tick_ext = clk_in_rise | clk_in_fall;
      default: tick_ext = 1'b0;
    endcase
  end

  // Moving between internal and external sources may add one step;
  // software is expected to avoid doing so at an external edge
  assign tick = tick_int | tick_ext;

  // Match is raised with the step that leaves the matching value, and is
  // withheld when the constant is being written in that cycle
  assign match_a = tick & (s_q.timer_count == s_q.time_constant_a) & ~wr_const_a;
  assign match_b = tick & (s_q.timer_count == s_q.time_constant_b) & ~wr_const_b;

  // Counter clear sources
  always_comb begin
    case (clear_sel)
      CLR_MATCH_A: clear_cnt = match_a;
      CLR_MATCH_B: clear_cnt = match_b;
      CLR_EXT: clear_cnt = rst_in_rise;
      default: clear_cnt = 1'b0;
    endcase
  end

  // Overflow only when the step itself moves FF to 00
  assign wrap_evt = tick & (s_q.timer_count == COUNT_MAX) & ~clear_cnt & ~wr_count;

  // Output actions of the channels that matched this cycle
  assign act_a = match_a ? out_act_t'(s_q.output_action_select[1:0]) : ACT_KEEP;
  assign act_b = match_b ? out_act_t'(s_q.output_action_select[3:2]) : ACT_KEEP;

  // Encodings rise with priority, so the larger code wins a conflict
  assign act = (act_b > act_a) ? act_b : act_a;

  // Next state of the whole channel
  always_comb begin
    s_d = s_q;

    // Bus: one wait cycle per access, then the final cycle
    s_d.ack = access & ~s_q.ack;

    // Read data captured in the wait cycle, shown in the final one
    if (avs_read && !s_q.ack) begin
      if (avs_address == OFS_COUNT) begin
        s_d.rdata = s_q.timer_count;
      end else if (avs_address == OFS_CONST_A) begin
        s_d.rdata = s_q.time_constant_a;
      end else if (avs_address == OFS_CONST_B) begin
        s_d.rdata = s_q.time_constant_b;
      end else if (avs_address == OFS_CONTROL) begin
        s_d.rdata = s_q.timer_control;
      end else if (avs_address == OFS_STATUS) begin
        s_d.rdata = status_view;
      end else begin
        // Unmapped offsets read as zero
        s_d.rdata = 8'h00;
      end
    end

    // Counter: clear beats write, write beats step
    if (clear_cnt) begin
      s_d.timer_count = 8'h00;
    end else if (wr_count) begin
      s_d.timer_count = wbyte;
    end else if (tick) begin
      s_d.timer_count = s_q.timer_count + 8'h01;
    end

    // Compare constants and control are plain read/write
    if (wr_const_a) begin
      s_d.time_constant_a = wbyte;
    end
    if (wr_const_b) begin
      s_d.time_constant_b = wbyte;
    end
    if (wr_control) begin
      s_d.timer_control = wbyte;
    end

    // Output select bits are writable; flags take only zeros
    if (wr_status) begin
      s_d.output_action_select = wbyte[STS_OS_HI:STS_OS_LO];
    end

    // Sticky flags: a zero written clears, a same-cycle event still sets
    s_d.match_flag_a = match_a |
                       (s_q.match_flag_a & ~(wr_status & ~wbyte[STS_FLAG_A]));
    s_d.match_flag_b = match_b |
                       (s_q.match_flag_b & ~(wr_status & ~wbyte[STS_FLAG_B]));
    s_d.wrap_flag = wrap_evt |
                    (s_q.wrap_flag & ~(wr_status & ~wbyte[STS_WRAP]));

    // Output pin follows the winning action
    case (act)
      ACT_LOW: s_d.tout = 1'b0;
      ACT_HIGH: s_d.tout = 1'b1;
      ACT_TOGGLE: s_d.tout = ~s_q.tout;
      default: s_d.tout = s_q.tout;
    endcase

    // Track the internal level to see its falling edges
    s_d.int_lvl_prev = int_lvl;
  end

  // State register; the output starts low and stays so until a match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.timer_count <= COUNT_RST;
      s_q.time_constant_a <= CONST_RST;
      s_q.time_constant_b <= CONST_RST;
      s_q.timer_control <= CONTROL_RST;
      s_q.match_flag_b <= STATUS_RST[STS_FLAG_B];
      s_q.match_flag_a <= STATUS_RST[STS_FLAG_A];
      s_q.wrap_flag <= STATUS_RST[STS_WRAP];
      s_q.output_action_select <= STATUS_RST[STS_OS_HI:STS_OS_LO];
      s_q.tout <= 1'b0;
      s_q.int_lvl_prev <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin output straight from its flop
  assign timer_out_ch0 = s_q.tout;

  // Separate request lines; the interrupt controller ranks A above B
  // above wrap, and this block keeps the lines apart so it can
  assign match_irq_a = s_q.match_flag_a & match_irq_enable_a;
  assign match_irq_b = s_q.match_flag_b & match_irq_enable_b;
  assign wrap_irq = s_q.wrap_flag & wrap_irq_enable;
endmodule

/* File: design/timer_edge_detect.sv */
// Edge detector for a pin input that is synchronous to clk
`timescale 1ns/1ps
module timer_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  // All state: the pin level one cycle ago
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t s_q;
  edge_state_t s_d;

  // Remember the last level
  always_comb begin
    s_d = s_q;
    s_d.prev = pin;
  end

  // State register; the pin is assumed low at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One-cycle pulses, in the same cycle the level change is seen
  assign rise = pin & ~s_q.prev;
  assign fall = ~pin & s_q.prev;
endmodule

/* File: design/timer_pkg.sv */
// Shared constants, register map and encodings of the 8-bit compare timer
package timer_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 8;
  // Register byte offsets (one aligned word each)
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CONST_A = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CONST_B = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  // timer_control field positions
  localparam int unsigned CTL_IRQ_EN_B = 7;
  localparam int unsigned CTL_IRQ_EN_A = 6;
  localparam int unsigned CTL_WRAP_EN = 5;
  localparam int unsigned CTL_CLR_HI = 4;
  localparam int unsigned CTL_CLR_LO = 3;
  localparam int unsigned CTL_CKS_HI = 2;
  localparam int unsigned CTL_CKS_LO = 0;
  // timer_control_status field positions
  localparam int unsigned STS_FLAG_B = 7;
  localparam int unsigned STS_FLAG_A = 6;
  localparam int unsigned STS_WRAP = 5;
  localparam int unsigned STS_FIXED = 4;
  localparam int unsigned STS_OS_HI = 3;
  localparam int unsigned STS_OS_LO = 0;
  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CONST_RST = 8'hff;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h10;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // Prescaler: counter width and the taps giving clk/8, clk/64, clk/1024
  localparam int unsigned PRE_W = 10;
  localparam int unsigned TAP_DIV8 = 2;
  localparam int unsigned TAP_DIV64 = 5;
  localparam int unsigned TAP_DIV1024 = 9;
  // Clock source select encodings
  typedef enum logic [2:0] {
    CKS_STOP0 = 3'h0, CKS_DIV8 = 3'h1, CKS_DIV64 = 3'h2, CKS_DIV1024 = 3'h3,
    CKS_STOP1 = 3'h4, CKS_EXT_RISE = 3'h5, CKS_EXT_FALL = 3'h6, CKS_EXT_BOTH = 3'h7
  } clock_sel_t;
  // Counter clear select encodings
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0, CLR_MATCH_A = 2'h1, CLR_MATCH_B = 2'h2, CLR_EXT = 2'h3
  } clear_sel_t;
  // Output action encodings; numeric order equals priority order
  typedef enum logic [1:0] {
    ACT_KEEP = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3
  } out_act_t;
endpackage

/* File: design/timer_prescaler.sv */
// Free-running prescaler producing the three internal source levels
`timescale 1ns/1ps
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int unsigned WIDTH = PRE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic lvl_div8,
  output logic lvl_div64,
  output logic lvl_div1024
);
  // Taps must exist inside the counter
  if (WIDTH < TAP_DIV1024 + 1) begin : g_bad_width
    $error("prescaler width too small for the divide-by-1024 tap");
  end

  // All state of the prescaler
  typedef struct packed {
    logic [WIDTH-1:0] div;
  } pre_state_t;

  pre_state_t s_q;
  pre_state_t s_d;

  // Binary counter; each tap is a square wave of the wanted period
  always_comb begin
    s_d = s_q;
    s_d.div = s_q.div + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl_div8 = s_q.div[TAP_DIV8];
  assign lvl_div64 = s_q.div[TAP_DIV64];
  assign lvl_div1024 = s_q.div[TAP_DIV1024];
endmodule
